// file: flash_map_pkg.sv
`default_nettype none
package flash_map_pkg;
    localparam int AXI_AW  = 8;
    localparam int AXI_DW  = 32;
    localparam int PTR_W   = 16;
    localparam int WADDR_W = 13;
    localparam int PAGE_W  = 7;
    localparam int WORD_W  = 6;
    localparam int BUF_WORDS = 64;

    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG  = 8'h00;
    localparam logic [7:0] OFS_POINTER = 8'h04;
    localparam logic [7:0] OFS_COMMAND = 8'h08;
    localparam logic [7:0] OFS_DATA    = 8'h0c;
    localparam logic [7:0] OFS_DECODE  = 8'h10;
    localparam logic [7:0] OFS_BOOT    = 8'h14;
    localparam logic [7:0] OFS_LOAD    = 8'h18;
    localparam logic [7:0] OFS_LAST_OP = 8'h1c;

    // Decode status field positions
    localparam int DEC_WORD_LSB = 8;
    localparam int DEC_BYTE_BIT = 16;
    localparam int DEC_BOOT_BIT = 17;
    localparam int DEC_HALT_BIT = 18;
    localparam int DEC_BUSY_BIT = 19;
    localparam int LOAD_BLK_BIT = 8;
    localparam int LAST_OP_LSB  = 8;

    localparam logic [1:0] SIZE_SEL_RESET = 2'h0;

    // Boot section starts, small and large counter variants
    localparam logic [12:0] BOOT_S_128 = 13'h0f80;
    localparam logic [12:0] BOOT_S_256 = 13'h0f00;
    localparam logic [12:0] BOOT_S_512 = 13'h0e00;
    localparam logic [12:0] BOOT_S_1K  = 13'h0c00;
    localparam logic [12:0] BOOT_L_128 = 13'h1f80;
    localparam logic [12:0] BOOT_L_256 = 13'h1f00;
    localparam logic [12:0] BOOT_L_512 = 13'h1e00;
    localparam logic [12:0] BOOT_L_1K  = 13'h1c00;
    localparam logic [12:0] BOOT_END_S = 13'h0fff;
    localparam logic [12:0] BOOT_END_L = 13'h1fff;
    localparam logic [12:0] RWW_LIMIT_S = 13'h0c00;
    localparam logic [12:0] RWW_LIMIT_L = 13'h1c00;
    localparam logic [6:0]  RWW_PAGES_S = 7'h60;
    localparam logic [6:0]  RWW_PAGES_L = 7'h70;

    // Command codes: bit0 enable, bit1 erase, bit2 write, bit4 re-enable
    localparam logic [4:0] CMD_FILL  = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_REEN  = 5'h11;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_ERASE = 2'b01,
        OP_WRITE = 2'b10
    } page_op_t;
endpackage
`default_nettype wire

// file: flash_addr_split.sv
`timescale 1ns/1ps
`default_nettype none
module flash_addr_split
    import flash_map_pkg::*;
#(
    parameter bit LARGE = 1'b0
)
(
    input  wire logic [15:0] ptr,         // Address pointer
    input  wire logic [1:0]  size_sel,    // Boot size selection
    output logic      [12:0] word_addr,   // Word address
    output logic      [6:0]  page_index,  // Page index
    output logic      [5:0]  word_index,  // Word in page
    output logic             byte_sel,    // Byte select
    output logic      [12:0] boot_start,  // Boot section start
    output logic             in_boot,     // Address in boot section
    output logic             in_halting   // Address in halting region
);
    always_comb
    begin
        byte_sel = ptr[0];
        if (LARGE)
        begin
            word_addr  = ptr[13:1];
            page_index = ptr[13:7];
            word_index = ptr[6:1];
            unique case (size_sel)
                2'b11: boot_start = BOOT_L_128;
                2'b10: boot_start = BOOT_L_256;
                2'b01: boot_start = BOOT_L_512;
                2'b00: boot_start = BOOT_L_1K;
            endcase
            in_halting = word_addr >= RWW_LIMIT_L;
        end
        else
        begin
            word_addr  = {1'b0, ptr[12:1]};
            page_index = ptr[12:6];
            word_index = {1'b0, ptr[5:1]};
            unique case (size_sel)
                2'b11: boot_start = BOOT_S_128;
                2'b10: boot_start = BOOT_S_256;
                2'b01: boot_start = BOOT_S_512;
                2'b00: boot_start = BOOT_S_1K;
            endcase
            in_halting = word_addr >= RWW_LIMIT_S;
        end
        in_boot = word_addr >= boot_start;
    end
endmodule // flash_addr_split
`default_nettype wire

// file: boot_section_page_address_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Small variant boot start 0xF80/0xF00/0xE00/0xC00 by selection, ending 0xFFF.
// - Large variant boot start 0x1F80/0x1F00/0x1E00/0x1C00, ending 0x1FFF.
// - Concurrent-read region below 0xC00 (small) or 0x1C00 (large).
// - Small variant: 32-word pages, word index PC[4:0], page PC[11:5].
// - Large variant: 64-word pages, word index PC[5:0], page PC[12:6].
// - Counter bits come from pointer one bit higher; pointer bit 0 excluded.
// - Page erase and page write target the pointer's page index.
// - Buffer fill writes the buffer word chosen by the word index.
// - Software keeps pointer bit 0 zero; loads use it as byte select.
// - Small variant ignores pointer bits 15 to 13.
// - Large variant ignores pointer bits 15 and 14.
// - Enable-only command stores the data word into the page buffer.
// - Page operation on concurrent region sets busy; busy blocks its reads.
module boot_section_page_address_decode
#(
    parameter bit LARGE = 1'b0
)
(
    input  wire logic                             CLK,         // 20 MHz clock
    input  wire logic                             RESETN,      // Async reset
    input  wire logic [flash_map_pkg::AXI_AW-1:0] AWADDR,      // Write address
    input  wire logic                             AWVALID,     // Write addr valid
    output logic                                  AWREADY,     // Write addr ready
    input  wire logic [flash_map_pkg::AXI_DW-1:0] WDATA,       // Write data
    input  wire logic [3:0]                       WSTRB,       // Byte strobes
    input  wire logic                             WVALID,      // Write data valid
    output logic                                  WREADY,      // Write data ready
    output logic [1:0]                            BRESP,       // Write response
    output logic                                  BVALID,      // Response valid
    input  wire logic                             BREADY,      // Response ready
    input  wire logic [flash_map_pkg::AXI_AW-1:0] ARADDR,      // Read address
    input  wire logic                             ARVALID,     // Read addr valid
    output logic                                  ARREADY,     // Read addr ready
    output logic [flash_map_pkg::AXI_DW-1:0]      RDATA,       // Read data
    output logic [1:0]                            RRESP,       // Read response
    output logic                                  RVALID,      // Read data valid
    input  wire logic                             RREADY,      // Read data ready
    output logic                                  REGION_BUSY, // Region busy flag
    output logic                                  IN_BOOT,     // Pointer in boot
    output logic                                  IN_HALTING   // Pointer halting
);
    import flash_map_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge CLK or negedge RESETN)
        if (!RESETN)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end

    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  size_sel_r;
    logic [15:0] ptr_r;
    logic [15:0] data_r;
    logic [4:0]  cmd_r;
    logic        busy_r;
    logic [6:0]  last_page_r;
    page_op_t    last_op_r;
    logic [15:0] page_buf [BUF_WORDS];

    logic [12:0] dec_word_addr;
    logic [6:0]  dec_page_index;
    logic [5:0]  dec_word_index;
    logic        dec_byte_sel;
    logic [12:0] dec_boot_start;
    logic        dec_in_boot;
    logic        dec_in_halting;

    flash_addr_split #(.LARGE(LARGE)) u_split (
        .ptr        (ptr_r),
        .size_sel   (size_sel_r),
        .word_addr  (dec_word_addr),
        .page_index (dec_page_index),
        .word_index (dec_word_index),
        .byte_sel   (dec_byte_sel),
        .boot_start (dec_boot_start),
        .in_boot    (dec_in_boot),
        .in_halting (dec_in_halting)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    logic       aw_held_r;
    logic       w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic       wr_fire;
    logic       wr_mapped;

    assign wr_fire = aw_held_r && w_held_r && !BVALID;

    always_comb
    begin
        unique case (awaddr_r)
            OFS_CONFIG, OFS_POINTER, OFS_COMMAND, OFS_DATA,
            OFS_DECODE, OFS_BOOT, OFS_LOAD, OFS_LAST_OP: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_r)
        if (!rst_n_r)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            AWREADY   <= 1'b1;
            WREADY    <= 1'b1;
            BVALID    <= 1'b0;
            BRESP     <= RESP_OKAY;
        end
        else
        begin
            if (AWVALID && AWREADY)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= {AWADDR[7:2], 2'b00};
                AWREADY   <= 1'b0;
            end
            if (WVALID && WREADY)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= WDATA;
                wstrb_r  <= WSTRB;
                WREADY   <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                BVALID    <= 1'b1;
                BRESP     <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (BVALID && BREADY)
            begin
                BVALID  <= 1'b0;
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end

    ////////////////////////////////////////////////////////////////////////
    // Software-visible configuration; read-only offsets ignore writes
    always_ff @(posedge CLK or negedge rst_n_r)
        if (!rst_n_r)
        begin
            size_sel_r <= SIZE_SEL_RESET;
            ptr_r      <= 16'h0000;
            data_r     <= 16'h0000;
        end
        else if (wr_fire)
        begin
            if (awaddr_r == OFS_CONFIG && wstrb_r[0])
                size_sel_r <= wdata_r[1:0];
            if (awaddr_r == OFS_POINTER)
            begin
                if (wstrb_r[0])
                    ptr_r[7:0] <= wdata_r[7:0];
                if (wstrb_r[1])
                    ptr_r[15:8] <= wdata_r[15:8];
            end
            if (awaddr_r == OFS_DATA)
            begin
                if (wstrb_r[0])
                    data_r[7:0] <= wdata_r[7:0];
                if (wstrb_r[1])
                    data_r[15:8] <= wdata_r[15:8];
            end
        end

    ////////////////////////////////////////////////////////////////////////
    // Commands; any code other than the four below is only recorded in cmd_r, with no action
    logic cmd_go;
    logic do_fill;
    logic do_erase;
    logic do_write;
    logic do_reen;

    assign cmd_go   = wr_fire && awaddr_r == OFS_COMMAND && wstrb_r[0];
    assign do_fill  = cmd_go && wdata_r[4:0] == CMD_FILL;
    assign do_erase = cmd_go && wdata_r[4:0] == CMD_ERASE;
    assign do_write = cmd_go && wdata_r[4:0] == CMD_WRITE;
    assign do_reen  = cmd_go && wdata_r[4:0] == CMD_REEN;

    always_ff @(posedge CLK or negedge rst_n_r)
        if (!rst_n_r)
        begin
            cmd_r       <= 5'h00;
            last_page_r <= 7'h00;
            last_op_r   <= OP_NONE;
        end
        else
        begin
            if (cmd_go)
                cmd_r <= wdata_r[4:0];
            // Word index bits are not checked on write; software keeps them 0
            if (do_erase || do_write)
            begin
                last_page_r <= dec_page_index;
                last_op_r   <= do_erase ? OP_ERASE : OP_WRITE;
            end
        end

    // No reset on the buffer: it is a memory, contents undefined until filled
    always_ff @(posedge CLK)
        if (do_fill)
            page_buf[dec_word_index] <= data_r;

    // Commands are exclusive, so a set and a clear never meet
    always_ff @(posedge CLK or negedge rst_n_r)
        if (!rst_n_r)
            busy_r <= 1'b0;
        else if ((do_erase || do_write) && !dec_in_halting)
            busy_r <= 1'b1;
        else if (do_reen || do_fill)
            busy_r <= 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Read channel, one cycle from address to data
    logic       rd_pend_r;
    logic [7:0] araddr_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_nxt;
    logic [15:0] load_word;
    logic       load_blocked;

    assign load_word    = page_buf[dec_word_index];
    assign load_blocked = busy_r && !dec_in_halting;

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = RESP_OKAY;
        unique case (araddr_r)
            OFS_CONFIG:  rdata_nxt[1:0] = size_sel_r;
            OFS_POINTER: rdata_nxt[15:0] = ptr_r;
            OFS_COMMAND: rdata_nxt[4:0] = cmd_r;
            OFS_DATA:    rdata_nxt[15:0] = data_r;
            OFS_DECODE:
            begin
                rdata_nxt[6:0] = dec_page_index;
                rdata_nxt[DEC_WORD_LSB +: 6] = dec_word_index;
                rdata_nxt[DEC_BYTE_BIT] = dec_byte_sel;
                rdata_nxt[DEC_BOOT_BIT] = dec_in_boot;
                rdata_nxt[DEC_HALT_BIT] = dec_in_halting;
                rdata_nxt[DEC_BUSY_BIT] = busy_r;
            end
            OFS_BOOT:    rdata_nxt[12:0] = dec_boot_start;
            OFS_LOAD:
            begin
                rdata_nxt[LOAD_BLK_BIT] = load_blocked;
                if (load_blocked)
                    rresp_nxt = RESP_SLVERR;
                else
                    rdata_nxt[7:0] = dec_byte_sel ? load_word[15:8]
                                                  : load_word[7:0];
            end
            OFS_LAST_OP:
            begin
                rdata_nxt[6:0] = last_page_r;
                rdata_nxt[LAST_OP_LSB +: 2] = last_op_r;
            end
            default:     rresp_nxt = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_r)
        if (!rst_n_r)
        begin
            rd_pend_r <= 1'b0;
            araddr_r  <= 8'h00;
            ARREADY   <= 1'b1;
            RVALID    <= 1'b0;
            RDATA     <= 32'h0000_0000;
            RRESP     <= RESP_OKAY;
        end
        else
        begin
            if (ARVALID && ARREADY)
            begin
                araddr_r  <= {ARADDR[7:2], 2'b00};
                rd_pend_r <= 1'b1;
                ARREADY   <= 1'b0;
            end
            if (rd_pend_r)
            begin
                rd_pend_r <= 1'b0;
                RVALID    <= 1'b1;
                RDATA     <= rdata_nxt;
                RRESP     <= rresp_nxt;
            end
            if (RVALID && RREADY)
            begin
                RVALID  <= 1'b0;
                ARREADY <= 1'b1;
            end
        end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge rst_n_r)
        if (!rst_n_r)
        begin
            REGION_BUSY <= 1'b0;
            IN_BOOT     <= 1'b0;
            IN_HALTING  <= 1'b0;
        end
        else
        begin
            REGION_BUSY <= busy_r;
            IN_BOOT     <= dec_in_boot;
            IN_HALTING  <= dec_in_halting;
        end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n_r);

    AST_BOOT_SIZE_SMALL: assert property (
        !LARGE |-> (BOOT_END_S - dec_boot_start + 13'h0001)
                   == (13'h0080 << (2'd3 - size_sel_r)))
        else $error("small boot size wrong");

    AST_BOOT_SIZE_LARGE: assert property (
        LARGE |-> (BOOT_END_L - dec_boot_start + 13'h0001)
                  == (13'h0080 << (2'd3 - size_sel_r)))
        else $error("large boot size wrong");

    AST_HALT_BY_PAGE: assert property (
        dec_in_halting == (dec_page_index >= (LARGE ? RWW_PAGES_L : RWW_PAGES_S)))
        else $error("region split not on page count");

    AST_POINTER_MAP: assert property (
        LARGE ? {dec_page_index, dec_word_index, dec_byte_sel} == ptr_r[13:0]
              : {dec_page_index, dec_word_index[4:0], dec_byte_sel} == ptr_r[12:0]
                && dec_word_index[5] == 1'b0)
        else $error("pointer split wrong");

    AST_HIGH_BITS_IGNORED: assert property (
        ptr_r != $past(ptr_r)
        && ((ptr_r ^ $past(ptr_r)) & (LARGE ? 16'h3fff : 16'h1fff)) == 16'h0000
        |-> $stable(dec_word_addr) && $stable(dec_in_boot))
        else $error("high pointer bits changed the address");

    AST_PAGE_OP_TARGET: assert property (
        do_erase || do_write |=> last_page_r == $past(dec_page_index))
        else $error("page op used wrong page");

    AST_FILL_WORD: assert property (
        do_fill |=> page_buf[$past(dec_word_index)] == $past(data_r))
        else $error("fill missed its buffer word");

    AST_BUSY_SET: assert property (
        (do_erase || do_write) && !dec_in_halting |=> ##1 REGION_BUSY)
        else $error("busy flag not raised");

    AST_LOAD_BLOCKED: assert property (
        rd_pend_r && araddr_r == OFS_LOAD && busy_r && !dec_in_halting
        |=> RVALID && RRESP == RESP_SLVERR)
        else $error("read of busy region not blocked");

    AST_BOOT_EDGE: assert property (
        (dec_word_addr == dec_boot_start |-> dec_in_boot)
        and (dec_word_addr == dec_boot_start - 13'h0001 |-> !dec_in_boot))
        else $error("boot indication off at boundary");

    AST_BVALID_HOLD: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");

    COV_FILL: cover property (do_fill ##[1:20] rd_pend_r && araddr_r == OFS_LOAD);
    COV_ERASE_RWW: cover property (do_erase && !dec_in_halting);
    COV_WRITE_HALT: cover property (do_write && dec_in_halting);
    COV_BLOCKED: cover property (RVALID && RRESP == RESP_SLVERR && busy_r);
endmodule // boot_section_page_address_decode
`default_nettype wire

// file: cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model
(
    input  wire logic        clk,     // Clock
    output var  logic [7:0]  awaddr,  // AW addr
    output var  logic        awvalid, // AW valid
    input  wire logic        awready, // AW ready
    output var  logic [31:0] wdata,   // W data
    output var  logic [3:0]  wstrb,   // W strobes
    output var  logic        wvalid,  // W valid
    input  wire logic        wready,  // W ready
    input  wire logic [1:0]  bresp,   // B resp
    input  wire logic        bvalid,  // B valid
    output var  logic        bready,  // B ready
    output var  logic [7:0]  araddr,  // AR addr
    output var  logic        arvalid, // AR valid
    input  wire logic        arready, // AR ready
    input  wire logic [31:0] rdata,   // R data
    input  wire logic [1:0]  rresp,   // R resp
    input  wire logic        rvalid,  // R valid
    output var  logic        rready   // R ready
);
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    ////////////////////////////////////////
    // Starts one edge late so bready is never assigned twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule // cpu_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import flash_map_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [31:0] rdata_l, rv_l;
    logic rvalid_l, region_busy_l, in_boot_l, in_halting_l;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, region_busy, in_boot, in_halting;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    boot_section_page_address_decode #(.LARGE(1'b0)) i_boot_section_page_address_decode (
        .CLK(clk), .RESETN(resetn), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .REGION_BUSY(region_busy),
        .IN_BOOT(in_boot), .IN_HALTING(in_halting));
    cpu_model i_cpu_model (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    // Large variant runs in lockstep on the same bus; its bus timing matches the small one
    boot_section_page_address_decode #(.LARGE(1'b1)) i_boot_section_page_address_decode_l (
        .CLK(clk), .RESETN(resetn), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(), .BRESP(), .BVALID(), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(), .RDATA(rdata_l),
        .RRESP(), .RVALID(rvalid_l), .RREADY(rready), .REGION_BUSY(region_busy_l),
        .IN_BOOT(in_boot_l), .IN_HALTING(in_halting_l));
    // Read data of the large instance, taken at its own handshake edge
    always @(posedge clk)
        if (rvalid_l && rready)
            rv_l <= rdata_l;
    ////////////////////////////////////////
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        i_cpu_model.wr(a, d, rs);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    endtask
    task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        i_cpu_model.rd(a, rv, rs);
        chk("rdata", e, rv);
        chk("rresp", {30'h0, er}, {30'h0, rs});
    endtask
    // Flag ports lag the pointer register by one cycle
    task automatic setp(input logic [15:0] p);
        w(OFS_POINTER, {16'h0, p});
        repeat (2) @(posedge clk);
    endtask
    task automatic dec(input logic [15:0] p, input logic [31:0] e);
        setp(p);
        r(OFS_DECODE, e, RESP_OKAY);
        chk("in_halting", {31'h0, e[DEC_HALT_BIT]}, {31'h0, in_halting});
        chk("in_boot", {31'h0, e[DEC_BOOT_BIT]}, {31'h0, in_boot});
    endtask
    ////////////////////////////////////////
    task automatic t_boot;
        logic [12:0] st [4];
        logic [12:0] sl [4];
        st = '{13'h0c00, 13'h0e00, 13'h0f00, 13'h0f80};
        sl = '{13'h1c00, 13'h1e00, 13'h1f00, 13'h1f80};
        for (int s = 0; s < 4; s++)
        begin
            w(OFS_CONFIG, 32'(s));
            r(OFS_BOOT, {19'h0, st[s]}, RESP_OKAY);
            @(posedge clk);
            chk("boot_large", {19'h0, sl[s]}, rv_l);
            setp({2'b0, st[s] - 13'h1, 1'b0});
            chk("in_boot", 32'h0, {31'h0, in_boot});
            setp({2'b0, st[s], 1'b0});
            chk("in_boot", 32'h1, {31'h0, in_boot});
        end
        $display("t_boot done");
    endtask
    task automatic t_split;
        dec(16'he7a3, 32'h0001111e);
        dec(16'h17fe, 32'h00001f5f);
        dec(16'hf800, 32'h00040060);
        dec(16'h1fff, 32'h00071f7f);
        $display("t_split done");
    endtask
    task automatic t_prog;
        w(OFS_DATA, 32'h0000a55a);
        setp(16'h000a);
        w(OFS_COMMAND, {27'h0, CMD_FILL});
        w(OFS_DATA, 32'h00001234);
        setp(16'h000c);
        w(OFS_COMMAND, {27'h0, CMD_FILL});
        setp(16'h000b);
        r(OFS_LOAD, 32'h000000a5, RESP_OKAY);
        setp(16'h000a);
        r(OFS_LOAD, 32'h0000005a, RESP_OKAY);
        setp(16'h00c0);
        w(OFS_COMMAND, {27'h0, CMD_ERASE});
        r(OFS_LAST_OP, 32'h00000103, RESP_OKAY);
        chk("region_busy", 32'h1, {31'h0, region_busy});
        setp(16'h000a);
        r(OFS_LOAD, 32'h00000100, RESP_SLVERR);
        w(OFS_COMMAND, {27'h0, CMD_REEN});
        repeat (2) @(posedge clk);
        chk("region_busy", 32'h0, {31'h0, region_busy});
        r(OFS_LOAD, 32'h0000005a, RESP_OKAY);
        setp(16'h1800);
        w(OFS_COMMAND, {27'h0, CMD_WRITE});
        r(OFS_LAST_OP, 32'h00000260, RESP_OKAY);
        chk("region_busy", 32'h0, {31'h0, region_busy});
        $display("t_prog done");
    endtask
    task automatic t_unmapped;
        i_cpu_model.wr(8'h20, 32'h0000ffff, rs);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        r(8'h20, 32'h0, RESP_SLVERR);
        $display("t_unmapped done");
    endtask
    // One pointer checked in both variants; es small, el large expectation
    task automatic decl(input logic [15:0] p, input logic [31:0] es, input logic [31:0] el);
        dec(p, es);
        @(posedge clk);
        chk("decode_large", el, rv_l);
        chk("halt_large", {31'h0, el[DEC_HALT_BIT]}, {31'h0, in_halting_l});
        chk("boot_large", {31'h0, el[DEC_BOOT_BIT]}, {31'h0, in_boot_l});
    endtask
    task automatic t_large;
        // Page write at 0x1800 lies in the large variant's concurrent region
        chk("busy_large", 32'h1, {31'h0, region_busy_l});
        w(OFS_COMMAND, {27'h0, CMD_REEN});
        decl(16'hb881, 32'h00050062, 32'h00050071);
        decl(16'h7fff, 32'h00071f7f, 32'h00073f7f);
        decl(16'hbfff, 32'h00071f7f, 32'h00073f7f);
        $display("t_large done");
    endtask
    ////////////////////////////////////////
    // Whole run is a few hundred cycles; ceiling leaves ample margin
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_boot;
        t_split;
        t_prog;
        t_unmapped;
        t_large;
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
